// ---- rtl/pmf_pkg.sv ----
// Purpose: Shared constants for the miscellaneous features control block
// Assumes: 125 MHz core clock, AXI4-Lite register access with 32-bit data
// Notes:   Register bits sit in the low half of the bus word
`default_nettype none
package pmf_pkg;
  localparam int unsigned CLK_FREQ_MHZ   = 125;       // Core clock rate
  localparam int unsigned AXI_ADDR_W     = 8;         // Byte address width
  localparam logic [7:0]  MISC_OFFSET    = 8'h10;     // Misc features register
  localparam logic [1:0]  RESP_OKAY      = 2'h0;      // AXI okay answer
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;      // AXI error answer
  // Field positions
  localparam int unsigned BIT_REPEATER   = 15;
  localparam int unsigned BIT_IRQ_POL    = 14;
  localparam int unsigned BIT_SQE_INHIB  = 11;
  localparam int unsigned BIT_LOOPBACK   = 10;
  localparam int unsigned BIT_AUX1_DATA  = 9;
  localparam int unsigned BIT_AUX1_DIR   = 8;
  localparam int unsigned BIT_AUX0_DATA  = 7;
  localparam int unsigned BIT_AUX0_DIR   = 6;
  localparam int unsigned BIT_APOL_DIS   = 5;
  localparam int unsigned BIT_POL_REV    = 4;
  localparam int unsigned BIT_RXCLK_GATE = 0;
  // Reset value: loopback on, both aux pins inputs, rest zero
  localparam logic [15:0] MISC_RESET     = 16'h0540;
  localparam logic [15:0] MISC_RSVD_MASK = 16'h300e;  // Reserved bits 13:12, 3:1
  // Timing counts
  localparam logic [3:0]  NLP_INV_COUNT  = 4'h8;      // Inverted link pulses to flag
  localparam logic [6:0]  RXCLK_HOLD     = 7'h40;     // Clock cycles after data valid falls
  localparam logic [1:0]  STRAP_SETTLE   = 2'h2;      // Cycles for strap through sync
  typedef enum logic [1:0] {GATE_RUN, GATE_HOLD, GATE_STOP} pmf_gate_e;
endpackage
`default_nettype wire

// ---- rtl/pmf_rxgate_if.sv ----
// Purpose: Carries receive clock gating signals between the register block and gate
// Assumes: Both ends on the core clock
// Notes:   ctrl drives the requests, gate returns the clock run and delayed data valid
`default_nettype none
interface pmf_rxgate_if;
  logic gate_enable;   // Gating bit from the register
  logic link_up;       // Link present
  logic force_run;     // Loopback or coding bypass active
  logic rx_dv_in;      // Raw receive data valid
  logic clk_run;       // Receive clock allowed to toggle
  logic rx_dv_out;     // Data valid aligned to the gated clock
  modport ctrl (output gate_enable, output link_up, output force_run, output rx_dv_in,
                input clk_run, input rx_dv_out);
  modport gate (input gate_enable, input link_up, input force_run, input rx_dv_in,
                output clk_run, output rx_dv_out);
endinterface
`default_nettype wire

// ---- rtl/pmf_rxgate.sv ----
// Purpose: Receive clock gating toward the media access controller
// Assumes: Raw data valid arrives on the core clock
// Notes:   Data valid leaves two cycles late so the clock can start one cycle early
`default_nettype none
module pmf_rxgate
  import pmf_pkg::*;
(
  input  wire logic     ref_clk_i,  // Core clock
  input  wire logic     reset_i,    // Synchronous reset, active high
  pmf_rxgate_if.gate    gate_if     // Gating controls and results
);
  pmf_gate_e  state;       // Gate state
  pmf_gate_e  next_state;
  logic [6:0] hold_cnt;    // Cycles since data valid fell
  logic [6:0] next_hold_cnt;
  logic       dv_d1;       // First delay stage of data valid
  logic       next_dv_d1;
  logic       dv_out;      // Second delay stage, seen by the controller
  logic       next_dv_out;
  logic       run;         // Clock run flag
  logic       next_run;
  logic       gating;      // Gating takes effect
  logic       active;      // Any data valid in flight

  assign gating = gate_if.gate_enable & gate_if.link_up & ~gate_if.force_run;
  assign active = gate_if.rx_dv_in | dv_d1 | dv_out;

  // Next state of the gate
  always_comb begin
    next_state    = state;
    next_hold_cnt = hold_cnt;
    next_run      = run;
    next_dv_d1    = gate_if.rx_dv_in;
    next_dv_out   = dv_d1;
    if (!gating) begin                      // Free running clock
      next_state    = GATE_RUN;
      next_run      = 1'b1;
      next_hold_cnt = 7'h00;
    end else begin
      case (state)
        GATE_RUN: begin                     // Running while data flows
          next_run = 1'b1;
          if (!active) begin
            next_state    = GATE_HOLD;
            next_hold_cnt = 7'h01;
          end
        end
        GATE_HOLD: begin                    // Keep clock after data valid fell
          next_run = 1'b1;
          if (active) begin
            next_state = GATE_RUN;
          end else if (hold_cnt == RXCLK_HOLD - 7'h01) begin
            next_state = GATE_STOP;
            next_run   = 1'b0;
          end else begin
            next_hold_cnt = hold_cnt + 7'h01;
          end
        end
        GATE_STOP: begin                    // Clock stopped while idle
          next_run = 1'b0;
          if (gate_if.rx_dv_in) begin       // Restart one cycle before data valid
            next_state = GATE_RUN;
            next_run   = 1'b1;
          end
        end
        default: begin
          next_state = GATE_RUN;
          next_run   = 1'b1;
        end
      endcase
    end
  end

  // Gate registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state    <= GATE_RUN;
      hold_cnt <= 7'h00;
      run      <= 1'b1;
      dv_d1    <= 1'b0;
      dv_out   <= 1'b0;
    end else begin
      state    <= next_state;
      hold_cnt <= next_hold_cnt;
      run      <= next_run;
      dv_d1    <= next_dv_d1;
      dv_out   <= next_dv_out;
    end
  end

  assign gate_if.clk_run   = run;
  assign gate_if.rx_dv_out = dv_out;
endmodule
`default_nettype wire

// ---- rtl/phy_misc_features_control.sv ----
// Purpose: Miscellaneous features control and status register of a 10/100 transceiver
// Assumes: AXI4-Lite master on the core clock; status strobes from core logic on same clock
// Notes:   Strap and aux pins pass a two stage synchroniser before use
//
// The AXI4-Lite interface to the registers was decided locally.
`default_nettype none
// Notes on behaviour
// - Repeater bit: no full duplex, receive-only CRS, no SQE
// - Interrupt pin polarity follows bit 14, default low
// - Bit 11 set suppresses the SQE test
// - SQE enabled: one COL pulse after transmission
// - Bit 10 enables 10BASE-T loopback, resets one
// - Bit 8 sets aux pin one direction
// - Bit 9 reads or drives aux pin one
// - Bit 6 sets aux pin zero direction
// - Bit 7 reads or drives aux pin zero
// - Bit 5 set disables automatic polarity correction
// - Auto mode: bit 4 shows detected inversion
// - Manual mode: bit 4 inverts transmitter polarity
// - Inversion after eight inverted NLPs or FLP burst
// - Bit 0 with link stops idle receive clock
// - Receive clock restarts one cycle before RX_DV
// - Receive clock stops 64 cycles after RX_DV
// - Bit 0 clear: receive clock runs continuously
// - Loopback or bypass keeps receive clock running
module phy_misc_features_control
  import pmf_pkg::*;
(
  input  wire logic                  ref_clk_i,            // Core clock
  input  wire logic                  reset_i,              // Synchronous reset, high
  // AXI4-Lite write address
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  // AXI4-Lite read address
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  // Pins
  input  wire logic                  repeater_strap_pin_i, // Repeater strap level
  output logic                       irq_output_pin_o,     // Interrupt pin level
  input  wire logic [1:0]            aux_pin_i,            // Aux pin levels
  output logic [1:0]                 aux_pin_o,            // Aux pin drive values
  output logic [1:0]                 aux_pin_oe_o,         // Aux pin drive enables
  // Core status
  input  wire logic                  irq_request_i,        // Core interrupt request
  input  wire logic                  ten_base_t_i,         // 10BASE-T mode active
  input  wire logic                  tx_en_i,              // MAC transmit enable
  input  wire logic                  nlp_strobe_i,         // Link pulse received
  input  wire logic                  flp_strobe_i,         // Fast link burst received
  input  wire logic                  pulse_inverted_i,     // Received pulse inverted
  input  wire logic                  link_up_i,            // Link present
  input  wire logic                  loopback_active_i,    // Any loopback mode on
  input  wire logic                  pcs_bypass_i,         // Coding sublayer bypass
  input  wire logic                  rx_dv_i,              // Raw receive data valid
  // Core controls
  output logic                       full_duplex_allow_o,  // Full duplex permitted
  output logic                       crs_rx_only_o,        // CRS on receive only
  output logic                       sqe_col_o,            // SQE test collision pulse
  output logic                       ten_loopback_o,       // 10BASE-T loopback on
  output logic                       rx_pol_invert_o,      // Receive polarity correction
  output logic                       tx_pol_invert_o,      // Transmit polarity invert
  output logic                       rx_clk_run_o,         // Receive clock enable
  output logic                       rx_dv_o               // Aligned receive data valid
);
  pmf_rxgate_if gate_if ();                 // Link to the clock gate

  // Synchronisers for pins
  logic [2:0] sync_a;                       // First stage: strap, aux pins
  logic [2:0] sync_b;                       // Second stage
  // Register and control state
  logic [15:0] misc;                        // Stored register bits
  logic [15:0] next_misc;
  logic [1:0]  strap_cnt;                   // Cycles since reset release
  logic [1:0]  next_strap_cnt;
  logic        pol_detect;                  // Inversion detected
  logic        next_pol_detect;
  logic [3:0]  nlp_cnt;                     // Consecutive inverted link pulses
  logic [3:0]  next_nlp_cnt;
  logic        tx_en_d;                     // Transmit enable last cycle
  logic        next_tx_en_d;
  logic [15:0] read_view;                   // Register as software sees it
  // Bus state
  logic        aw_held;                     // Write address taken
  logic        next_aw_held;
  logic        w_held;                      // Write data taken
  logic        next_w_held;
  logic [AXI_ADDR_W-1:0] aw_addr;           // Taken write address
  logic [AXI_ADDR_W-1:0] next_aw_addr;
  logic [31:0] w_data;                      // Taken write data
  logic [31:0] next_w_data;
  logic [3:0]  w_strb;                      // Taken byte strobes
  logic [3:0]  next_w_strb;
  logic        bvalid;
  logic        next_bvalid;
  logic [1:0]  bresp;
  logic [1:0]  next_bresp;
  logic        rvalid;
  logic        next_rvalid;
  logic [1:0]  rresp;
  logic [1:0]  next_rresp;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        do_write;                    // Address and data both present
  logic        hit_write;                   // Write to the mapped register
  logic [15:0] wmask;                       // Bits written by strobes
  // Registered outputs
  logic [7:0]  outs;                        // Control outputs
  logic [7:0]  next_outs;
  logic [1:0]  aux_o;
  logic [1:0]  next_aux_o;
  logic [1:0]  aux_oe;
  logic [1:0]  next_aux_oe;

  // Pin synchroniser, second stage alone feeds logic
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {repeater_strap_pin_i, aux_pin_i};
      sync_b <= sync_a;
    end
  end

  // Register view: reserved reads zero, pin bits follow direction
  always_comb begin
    read_view = misc & ~MISC_RSVD_MASK;
    if (misc[BIT_AUX1_DIR]) begin
      read_view[BIT_AUX1_DATA] = sync_b[1];
    end
    if (misc[BIT_AUX0_DIR]) begin
      read_view[BIT_AUX0_DATA] = sync_b[0];
    end
    if (!misc[BIT_APOL_DIS]) begin
      read_view[BIT_POL_REV] = pol_detect;
    end
  end

  assign do_write  = aw_held & w_held & ~bvalid;
  assign hit_write = do_write & (aw_addr == MISC_OFFSET);
  assign wmask     = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  // Next values of the register, strap load and polarity detector
  always_comb begin
    next_misc       = misc;
    next_strap_cnt  = strap_cnt;
    next_pol_detect = pol_detect;
    next_nlp_cnt    = nlp_cnt;
    next_tx_en_d    = tx_en_i;
    if (hit_write) begin                    // Reserved bits kept at zero
      next_misc = ((misc & ~wmask) | (w_data[15:0] & wmask)) & ~MISC_RSVD_MASK;
    end
    if (strap_cnt != STRAP_SETTLE + 2'h1) begin // Strap seen through synchroniser
      next_strap_cnt = strap_cnt + 2'h1;
      if (strap_cnt == STRAP_SETTLE) begin
        next_misc[BIT_REPEATER] = sync_b[2];
      end
    end
    if (nlp_strobe_i) begin                 // Eight inverted link pulses
      if (!pulse_inverted_i) begin
        next_nlp_cnt    = 4'h0;
        next_pol_detect = 1'b0;
      end else if (nlp_cnt == NLP_INV_COUNT - 4'h1) begin
        next_nlp_cnt    = NLP_INV_COUNT;
        next_pol_detect = 1'b1;
      end else if (nlp_cnt != NLP_INV_COUNT) begin
        next_nlp_cnt = nlp_cnt + 4'h1;
      end
    end
    if (flp_strobe_i) begin                 // One inverted burst suffices
      next_pol_detect = pulse_inverted_i;
      next_nlp_cnt    = 4'h0;
    end
  end

  // Register state
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      misc       <= MISC_RESET;             // Defaults
      strap_cnt  <= 2'h0;
      pol_detect <= 1'b0;
      nlp_cnt    <= 4'h0;
      tx_en_d    <= 1'b0;
    end else begin
      misc       <= next_misc;
      strap_cnt  <= next_strap_cnt;
      pol_detect <= next_pol_detect;
      nlp_cnt    <= next_nlp_cnt;
      tx_en_d    <= next_tx_en_d;
    end
  end

  // Next values of the bus slave
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    if (!aw_held && s_axi_awvalid_i) begin  // Address taken alone or with data
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (!w_held && s_axi_wvalid_i) begin    // Data taken alone or with address
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (do_write) begin                     // Answer once both are held
      next_bvalid  = 1'b1;
      next_bresp   = hit_write ? RESP_OKAY : RESP_SLVERR;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
    if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
    if (!rvalid && s_axi_arvalid_i) begin   // Read answered next cycle
      next_rvalid = 1'b1;
      if (s_axi_araddr_i == MISC_OFFSET) begin
        next_rdata = {16'h0000, read_view};
        next_rresp = RESP_OKAY;
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_SLVERR;
      end
    end else if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
  end

  // Bus slave state
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= RESP_OKAY;
      rdata   <= 32'h0000_0000;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
    end
  end

  // Next values of the control outputs and pins
  always_comb begin
    next_outs[0] = ~misc[BIT_REPEATER];
    next_outs[1] = misc[BIT_REPEATER];
    next_outs[2] = tx_en_d & ~tx_en_i & ten_base_t_i
                   & ~misc[BIT_SQE_INHIB] & ~misc[BIT_REPEATER];
    next_outs[3] = misc[BIT_LOOPBACK] & ten_base_t_i;
    next_outs[4] = ~misc[BIT_APOL_DIS] & pol_detect;
    next_outs[5] = misc[BIT_APOL_DIS] & misc[BIT_POL_REV];
    next_outs[6] = misc[BIT_IRQ_POL] ? irq_request_i : ~irq_request_i;
    next_outs[7] = 1'b0;
    next_aux_oe  = {~misc[BIT_AUX1_DIR], ~misc[BIT_AUX0_DIR]};
    next_aux_o   = {misc[BIT_AUX1_DATA], misc[BIT_AUX0_DATA]};
  end

  // Output registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      outs   <= 8'h41;                      // Duplex allowed, interrupt idle high
      aux_o  <= 2'h0;
      aux_oe <= 2'h0;
    end else begin
      outs   <= next_outs;
      aux_o  <= next_aux_o;
      aux_oe <= next_aux_oe;
    end
  end

  // Receive clock gate controls
  assign gate_if.gate_enable = misc[BIT_RXCLK_GATE];
  assign gate_if.link_up     = link_up_i;
  assign gate_if.force_run   = loopback_active_i | pcs_bypass_i;
  assign gate_if.rx_dv_in    = rx_dv_i;

  pmf_rxgate u_rxgate (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .gate_if   (gate_if)
  );

  assign s_axi_awready_o     = ~aw_held;
  assign s_axi_wready_o      = ~w_held;
  assign s_axi_bresp_o       = bresp;
  assign s_axi_bvalid_o      = bvalid;
  assign s_axi_arready_o     = ~rvalid;
  assign s_axi_rdata_o       = rdata;
  assign s_axi_rresp_o       = rresp;
  assign s_axi_rvalid_o      = rvalid;
  assign full_duplex_allow_o = outs[0];
  assign crs_rx_only_o       = outs[1];
  assign sqe_col_o           = outs[2];
  assign ten_loopback_o      = outs[3];
  assign rx_pol_invert_o     = outs[4];
  assign tx_pol_invert_o     = outs[5];
  assign irq_output_pin_o    = outs[6];
  assign aux_pin_o           = aux_o;
  assign aux_pin_oe_o        = aux_oe;
  assign rx_clk_run_o        = gate_if.clk_run;
  assign rx_dv_o             = gate_if.rx_dv_out;
endmodule
`default_nettype wire

// ---- test/pmf_asserts.sv ----
// Purpose: Port-level checks of the misc features block
// Assumes: Bound to the top module, one clock domain
// Notes:   Idle counter judges clock stop
`default_nettype none
module pmf_asserts (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic full_duplex_allow_o,
  input wire logic crs_rx_only_o,
  input wire logic sqe_col_o,
  input wire logic tx_en_i,
  input wire logic link_up_i,
  input wire logic loopback_active_i,
  input wire logic pcs_bypass_i,
  input wire logic rx_dv_i,
  input wire logic rx_dv_o,
  input wire logic rx_clk_run_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic [6:0] low_cnt; // Cycles since data valid fell
  // Saturating idle counter
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || rx_dv_o) low_cnt <= 7'h0;
    else if (low_cnt != 7'h7f) low_cnt <= low_cnt + 7'h1;
  end
  property p_dup; full_duplex_allow_o != crs_rx_only_o; endproperty
  a_dup: assert property (p_dup) else $error("duplex and crs disagree");
  property p_sqe_one; sqe_col_o |=> !sqe_col_o; endproperty
  a_sqe_one: assert property (p_sqe_one) else $error("long sqe pulse");
  property p_sqe_rpt; sqe_col_o |-> !crs_rx_only_o; endproperty
  a_sqe_rpt: assert property (p_sqe_rpt) else $error("sqe in repeater");
  property p_sqe_end;
    sqe_col_o |-> !$past(tx_en_i) && ($past(tx_en_i, 2) || $past(tx_en_i, 3) || $past(tx_en_i, 4));
  endproperty
  a_sqe_end: assert property (p_sqe_end) else $error("sqe without end");
  property p_lnk; !link_up_i |=> rx_clk_run_o; endproperty
  a_lnk: assert property (p_lnk) else $error("clock off without link");
  property p_byp; loopback_active_i || pcs_bypass_i |=> rx_clk_run_o; endproperty
  a_byp: assert property (p_byp) else $error("clock off in loopback");
  property p_early; $rose(rx_dv_o) |-> $past(rx_clk_run_o); endproperty
  a_early: assert property (p_early) else $error("clock late");
  property p_dly; rx_dv_o == $past(rx_dv_i, 2); endproperty
  a_dly: assert property (p_dly) else $error("data valid delay");
  property p_hold; $fell(rx_dv_o) |-> ##62 rx_clk_run_o; endproperty
  a_hold: assert property (p_hold) else $error("clock stopped early");
  property p_stop; $fell(rx_clk_run_o) |-> low_cnt >= 7'd60 && !$past(rx_dv_i); endproperty
  a_stop: assert property (p_stop) else $error("clock stopped busy");
  c_sqe: cover property (sqe_col_o);
  c_stop: cover property ($fell(rx_clk_run_o));
  c_rx: cover property ($rose(rx_dv_o));
endmodule
bind phy_misc_features_control pmf_asserts pmf_asserts_i (.ref_clk_i, .reset_i,
  .full_duplex_allow_o, .crs_rx_only_o, .sqe_col_o, .tx_en_i, .link_up_i,
  .loopback_active_i, .pcs_bypass_i, .rx_dv_i, .rx_dv_o, .rx_clk_run_o);
`default_nettype wire

// ---- test/pmf_line_model.sv ----
// Purpose: Core and line traffic toward the block
// Assumes: Driven just after rising edges
// Notes:   Qualifier shows the inverse once released
`default_nettype none
module pmf_line_model (
  input  wire logic clk_i,
  output logic      tx_en_o,
  output logic      rx_dv_o,
  output logic      nlp_o,
  output logic      flp_o,
  output logic      inv_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet line at start
  initial begin
    {tx_en_o, rx_dv_o, nlp_o, flp_o, inv_o} = 5'h0;
  end
  // Transmit packet of n cycles
  task automatic tx(input int n);
    tx_en_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    tx_en_o <= 1'b0;
  endtask
  // Received frame of n cycles
  task automatic rx(input int n);
    rx_dv_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    rx_dv_o <= 1'b0;
  endtask
  // One-cycle link pulse or burst
  task automatic pulse(input logic f, input logic i);
    nlp_o <= !f;
    flp_o <= f;
    inv_o <= i;
    @(posedge clk_i);
    {nlp_o, flp_o} <= 2'h0;
    inv_o <= !i;
  endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: Self-checking bench of the misc register
// Assumes: Response readies held high
// Notes:   Random writes keep reserved bits zero
`default_nettype none
module testbench
  import pmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, strp, awv, wv, arv, irq_req, tbt, lnk, lpb, byp, txe, rdv, nlp, flp, inv;
  logic awr, wr, bv, arr, rv, irq_o, fdx, crs, sqe, lb, rxp, txp, run, dvo;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd, v;
  logic [1:0] br, rr, aux_i, aux_o, aux_oe, r;
  logic [15:0] d, e;
  int err_total, check_count, n, seed;
  phy_misc_features_control phy_misc_features_control_i (
    .ref_clk_i(clk), .reset_i(rst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
    .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1),
    .repeater_strap_pin_i(strp), .irq_output_pin_o(irq_o), .aux_pin_i(aux_i),
    .aux_pin_o(aux_o), .aux_pin_oe_o(aux_oe), .irq_request_i(irq_req), .ten_base_t_i(tbt),
    .tx_en_i(txe), .nlp_strobe_i(nlp), .flp_strobe_i(flp), .pulse_inverted_i(inv),
    .link_up_i(lnk), .loopback_active_i(lpb), .pcs_bypass_i(byp), .rx_dv_i(rdv),
    .full_duplex_allow_o(fdx), .crs_rx_only_o(crs), .sqe_col_o(sqe), .ten_loopback_o(lb),
    .rx_pol_invert_o(rxp), .tx_pol_invert_o(txp), .rx_clk_run_o(run), .rx_dv_o(dvo));
  pmf_line_model pmf_line_model_i (.clk_i(clk), .tx_en_o(txe), .rx_dv_o(rdv),
    .nlp_o(nlp), .flp_o(flp), .inv_o(inv));
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      $display("unexpected t=%0t got %h exp %h", $time, g, x);
      err_total++;
    end
  endtask
  // AXI write, both channels at once
  task automatic axw(input logic [7:0] a, input logic [15:0] dd, output logic [1:0] rs);
    logic ta, tw, tv;
    int k;
    @(posedge clk);
    k = 0;
    awa <= a; wd <= {16'h0, dd}; awv <= 1'b1; wv <= 1'b1;
    do begin
      @(negedge clk);
      ta = awr; tw = wr; tv = bv; rs = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      k++;
    end while (!tv && k < 50);
    if (!tv) err_total++;
  endtask
  // AXI read
  task automatic axr(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rs);
    logic ta, tv;
    int k;
    @(posedge clk);
    k = 0;
    ara <= a; arv <= 1'b1;
    do begin
      @(negedge clk);
      ta = arr; tv = rv; dd = rd; rs = rr;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      k++;
    end while (!tv && k < 50);
    if (!tv) err_total++;
  endtask
  // Expected read value
  function automatic logic [15:0] exp_rd(input logic [15:0] x, input logic [1:0] p);
    exp_rd = x;
    if (x[8]) exp_rd[9] = p[1];
    if (x[6]) exp_rd[7] = p[0];
    if (!x[5]) exp_rd[4] = 1'b0;
  endfunction
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    err_total++;
    finish_test();
  end
  // Main sequence
  initial begin
    seed = 32'h9cfa;
    {strp, rst, awv, wv, arv, irq_req, tbt, lnk, lpb, byp} = {1'($random(seed)), 9'h100};
    {awa, ara, wd, aux_i} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    axr(MISC_OFFSET, v, r);
    chk({r, v[29:0]},
      {RESP_OKAY, 14'h0, MISC_RESET | {strp, 15'h0}});
    axr(8'h14, v, r);
    chk({r, v[29:0]}, {RESP_SLVERR, 30'h0});
    axw(8'h14, 16'h0, r);
    chk(32'(r), 32'(RESP_SLVERR));
    $display("test map done");
    for (int i = 0; i < 8; i++) begin
      d = 16'($random(seed)) & 16'hcff1;
      aux_i <= 2'($random(seed));
      irq_req <= 1'($random(seed));
      tbt <= 1'($random(seed));
      axw(MISC_OFFSET, d, r);
      repeat (4) @(posedge clk);
      axr(MISC_OFFSET, v, r);
      chk(v, {16'h0, exp_rd(d, aux_i)});
      @(negedge clk);
      chk(32'({crs, fdx, lb, txp, irq_o, aux_oe, aux_o & aux_oe}), 32'({d[15], !d[15],
        d[10] & tbt, d[5] & d[4], d[14] ~^ irq_req, !d[8], !d[6], d[9] & !d[8],
        d[7] & !d[6]}));
    end
    $display("test random done");
    axw(MISC_OFFSET, 16'h0, r);
    for (int i = 0; i < 10; i++) begin
      pmf_line_model_i.pulse(i == 9, i != 8);
      axr(MISC_OFFSET, v, r);
      @(negedge clk);
      chk(32'({v[4], rxp}), {30'h0, {2{i == 7 || i == 9}}});
    end
    $display("test polarity done");
    tbt <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      axw(MISC_OFFSET, (i == 0) ? 16'h0 : ((i == 1) ? 16'h0800 : 16'h8000), r);
      n = 0;
      fork
        pmf_line_model_i.tx(12);
        repeat (20) begin
          @(negedge clk);
          if (sqe === 1'b1) n++;
        end
      join
      chk(32'(n), 32'(i == 0));
    end
    $display("test sqe done");
    lnk <= 1'b1;
    axw(MISC_OFFSET, 16'h0001, r);
    repeat (70) @(posedge clk);
    chk(32'(run), 32'h0);
    pmf_line_model_i.rx(20);
    n = 0;
    while (dvo !== 1'b0 && n < 10) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (run === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n >= 63 && n <= 65), 32'h1);
    byp <= 1'b1;
    repeat (2) @(negedge clk);
    chk(32'(run), 32'h1);
    byp <= 1'b0;
    repeat (70) @(posedge clk);
    axw(MISC_OFFSET, 16'h0, r);
    @(negedge clk);
    chk(32'(run), 32'h1);
    $display("test rx clock done");
    finish_test();
  end
endmodule
`default_nettype wire
